// File: rtl/bsnsu_top.sv
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// - subtract accumulator and borrow from file value
// - direction bit 0 accumulator, 1 file register
// - access bit 0 access bank, 1 banked
// - extended set: f up to 95 indexed
// - swap nibbles, status flags left untouched
module bsnsu_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // instruction port
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  output logic             instr_ready,
  output logic             instr_done,
  // data memory port, read data one cycle after mem_rd
  output logic      [11:0] mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata
);
  bsnsu_pkg::bsnsu_state_e state;       // sequencer state
  logic        ext_en;                  // extended set enable
  logic [7:0]  wreg;                    // accumulator
  logic [4:0]  stat;                    // N OV Z DC C
  logic [3:0]  bank;                    // bank_select_value
  logic [11:0] idx_base;                // indexed base pointer
  logic        op_sub;                  // 1 subtract, 0 swap
  logic        dest_f;                  // direction bit
  logic [11:0] next_addr;               // resolved operand address
  logic        take;                    // instruction accepted
  logic        known;                   // opcode handled here
  logic [8:0]  sum9;                    // full byte difference
  logic [4:0]  sum5;                    // low nibble difference
  logic [7:0]  res;                     // operation result
  logic        bus_stat_wr;             // software writes status
  logic        bus_wreg_wr;             // software writes accumulator

  assign known = (instr_word[15:10] == bsnsu_pkg::OPC_SUBB) ||
                 (instr_word[15:10] == bsnsu_pkg::OPC_SWAP);
  assign take  = ce && instr_valid && instr_ready && known;
  assign bus_stat_wr = reg_wr && (reg_addr == bsnsu_pkg::OFS_STAT);
  assign bus_wreg_wr = reg_wr && (reg_addr == bsnsu_pkg::OFS_WREG);

  // operand address resolution
  bsnsu_addr_map u_map (
    .f_ofs    (instr_word[7:0]),
    .acc_sel  (instr_word[bsnsu_pkg::POS_A]),
    .ext_en   (ext_en),
    .bank     (bank),
    .idx_base (idx_base),
    .addr     (next_addr)
  );

  // f + ~w + c equals f - w - !c; carry out means no borrow
  assign sum9 = {1'b0, mem_rdata} + {1'b0, ~wreg}
              + {8'h00, stat[bsnsu_pkg::ST_C]};
  assign sum5 = {1'b0, mem_rdata[3:0]} + {1'b0, ~wreg[3:0]}
              + {4'h0, stat[bsnsu_pkg::ST_C]};
  // swap places low nibble high and high nibble low
  assign res  = op_sub ? sum9[7:0]
                       : {mem_rdata[3:0], mem_rdata[7:4]};

  // sequencer: issue read, wait, write back
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= bsnsu_pkg::ST_IDLE;
    end else if (ce) begin
      case (state)
        bsnsu_pkg::ST_IDLE:  if (take) state <= bsnsu_pkg::ST_READ;
        bsnsu_pkg::ST_READ:  state <= bsnsu_pkg::ST_WAIT;
        bsnsu_pkg::ST_WAIT:  state <= bsnsu_pkg::ST_WRITE;
        default:             state <= bsnsu_pkg::ST_IDLE;
      endcase
    end
  end

  // instruction handshake; ready drops for the whole sequence
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      instr_ready <= 1'b1;
      instr_done  <= 1'b0;
    end else if (ce) begin
      instr_done <= (state == bsnsu_pkg::ST_WRITE);
      if (take) begin
        instr_ready <= 1'b0;
      end else if (state == bsnsu_pkg::ST_WRITE) begin
        instr_ready <= 1'b1;
      end
    end
  end

  // operand capture at acceptance
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      op_sub   <= 1'b0;
      dest_f   <= 1'b1;
      mem_addr <= 12'h000;
    end else if (ce && take) begin
      op_sub   <= (instr_word[15:10] == bsnsu_pkg::OPC_SUBB);
      dest_f   <= instr_word[bsnsu_pkg::POS_D];
      mem_addr <= next_addr;
    end
  end

  // memory strobes, one cycle each
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_wdata <= 8'h00;
    end else if (ce) begin
      mem_rd <= take;
      mem_wr <= (state == bsnsu_pkg::ST_WAIT) && dest_f;
      if (state == bsnsu_pkg::ST_WAIT) begin
        mem_wdata <= res;
      end
    end
  end

  // accumulator; software write wins over a result in flight
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wreg <= bsnsu_pkg::RST_WREG;
    end else if (ce) begin
      if (bus_wreg_wr) begin
        wreg <= reg_wdata[7:0];
      end else if (state == bsnsu_pkg::ST_WAIT && !dest_f) begin
        wreg <= res;
      end
    end
  end

  // status flags, written by software and by subtraction, never by swap
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat <= bsnsu_pkg::RST_STAT;
    end else if (ce) begin
      if (bus_stat_wr) begin
        stat <= reg_wdata[4:0];
      end else if (state == bsnsu_pkg::ST_WAIT && op_sub) begin
        stat[bsnsu_pkg::ST_C]  <= sum9[8];
        stat[bsnsu_pkg::ST_DC] <= sum5[4];
        stat[bsnsu_pkg::ST_Z]  <= (sum9[7:0] == 8'h00);
        stat[bsnsu_pkg::ST_N]  <= sum9[7];
        // signed overflow: operands differ in sign, result flips
        stat[bsnsu_pkg::ST_OV] <= (mem_rdata[7] ^ wreg[7]) &&
                                  (sum9[7] ^ mem_rdata[7]);
      end
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ext_en   <= bsnsu_pkg::RST_EXT;
      bank     <= bsnsu_pkg::RST_BANK;
      idx_base <= bsnsu_pkg::RST_INDEX;
    end else if (ce && reg_wr) begin
      if (reg_addr == bsnsu_pkg::OFS_CTRL) begin
        ext_en <= reg_wdata[0];
      end else if (reg_addr == bsnsu_pkg::OFS_BANK) begin
        bank <= reg_wdata[3:0];
      end else if (reg_addr == bsnsu_pkg::OFS_INDEX) begin
        idx_base <= reg_wdata[11:0];
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      if (!reg_rd) begin
        reg_rdata <= 32'h00000000;
      end else if (reg_addr == bsnsu_pkg::OFS_CTRL) begin
        reg_rdata <= {31'h00000000, ext_en};
      end else if (reg_addr == bsnsu_pkg::OFS_WREG) begin
        reg_rdata <= {24'h000000, wreg};
      end else if (reg_addr == bsnsu_pkg::OFS_STAT) begin
        reg_rdata <= {27'h0000000, stat};
      end else if (reg_addr == bsnsu_pkg::OFS_BANK) begin
        reg_rdata <= {28'h0000000, bank};
      end else if (reg_addr == bsnsu_pkg::OFS_INDEX) begin
        reg_rdata <= {20'h00000, idx_base};
      end else begin
        // unmapped reads as zero
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // assertions; helpers assume ce high across a sequence
  logic in_wait;  // final compute cycle
  assign in_wait = (state == bsnsu_pkg::ST_WAIT) && ce;

  sequence wait_sub_f;
    in_wait && op_sub && dest_f;
  endsequence

  sequence wait_to_acc;
    in_wait && !dest_f && !bus_wreg_wr;
  endsequence

  sub_result_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wait_sub_f |=> mem_wr && (mem_wdata == 8'($past(mem_rdata)
      - $past(wreg) - {7'h00, !$past(stat[bsnsu_pkg::ST_C])})))
    else $error("subtract with borrow result wrong");

  dest_acc_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    wait_to_acc |=> !mem_wr && (wreg == ($past(op_sub)
      ? 8'($past(mem_rdata) - $past(wreg)
           - {7'h00, !$past(stat[bsnsu_pkg::ST_C])})
      : {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})))
    else $error("direction 0 did not load accumulator");

  bank_addr_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (take && instr_word[bsnsu_pkg::POS_A]) |=>
      mem_addr == {$past(bank), $past(instr_word[7:0])})
    else $error("banked address wrong");

  indexed_addr_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (take && !instr_word[bsnsu_pkg::POS_A] && ext_en &&
     instr_word[7:0] <= bsnsu_pkg::IDX_LIMIT) |=>
      mem_addr == 12'($past(idx_base) + {4'h0, $past(instr_word[7:0])}))
    else $error("indexed literal offset address wrong");

  swap_flags_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (in_wait && !op_sub && dest_f && !bus_stat_wr) |=>
      mem_wr && stat == $past(stat) &&
      mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
    else $error("nibble swap wrong or flags disturbed");

  borrow_flag_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (in_wait && op_sub && !bus_stat_wr) |=>
      stat[bsnsu_pkg::ST_C] == ({1'b0, $past(mem_rdata)} >=
        {1'b0, $past(wreg)} + {8'h00, !$past(stat[bsnsu_pkg::ST_C])}))
    else $error("carry does not reflect borrow");
endmodule : bsnsu_top

// File: rtl/bsnsu_pkg.sv
package bsnsu_pkg;
  // register bus geometry
  localparam int unsigned BUS_AW = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;  // extended set enable
  localparam logic [7:0] OFS_WREG  = 8'h04;  // accumulator
  localparam logic [7:0] OFS_STAT  = 8'h08;  // status flags
  localparam logic [7:0] OFS_BANK  = 8'h0C;  // bank select value
  localparam logic [7:0] OFS_INDEX = 8'h10;  // indexed offset base

  // status field positions
  localparam int unsigned ST_C  = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z  = 2;
  localparam int unsigned ST_OV = 3;
  localparam int unsigned ST_N  = 4;

  // values after reset
  localparam logic [7:0]  RST_WREG  = 8'h00;
  localparam logic [4:0]  RST_STAT  = 5'h00;
  localparam logic [3:0]  RST_BANK  = 4'h0;
  localparam logic [11:0] RST_INDEX = 12'h000;
  localparam logic        RST_EXT   = 1'b0;

  // opcode fields, upper six bits of the instruction word
  localparam logic [5:0] OPC_SUBB = 6'h16;  // subtract_with_borrow_op
  localparam logic [5:0] OPC_SWAP = 6'h0E;  // nibble_swap_op
  localparam int unsigned POS_D = 9;
  localparam int unsigned POS_A = 8;

  // addressing limits
  localparam logic [7:0]  IDX_LIMIT    = 8'h5F;  // highest indexed f
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;  // low/high access half
  localparam logic [3:0]  ACCESS_HIGH  = 4'hF;   // bank of upper half

  // sequencer states, gray along the path
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_WAIT  = 2'h3,
    ST_WRITE = 2'h2
  } bsnsu_state_e;
endpackage : bsnsu_pkg

// File: rtl/bsnsu_addr_map.sv
`timescale 1ns/1ps
// resolves an 8-bit file operand into a 12-bit data address
module bsnsu_addr_map (
  input  wire logic [7:0]  f_ofs,
  input  wire logic        acc_sel,
  input  wire logic        ext_en,
  input  wire logic [3:0]  bank,
  input  wire logic [11:0] idx_base,
  output logic      [11:0] addr
);
  always_comb begin
    if (acc_sel) begin
      // banked general_purpose_file_bank access
      addr = {bank, f_ofs};
    end else if (ext_en && (f_ofs <= bsnsu_pkg::IDX_LIMIT)) begin
      // indexed literal offset, wraps inside data space
      addr = idx_base + {4'h0, f_ofs};
    end else if (f_ofs < bsnsu_pkg::ACCESS_SPLIT) begin
      // low half of access bank
      addr = {4'h0, f_ofs};
    end else begin
      // upper half of access bank maps to top of space
      addr = {bsnsu_pkg::ACCESS_HIGH, f_ofs};
    end
  end
endmodule : bsnsu_addr_map

// File: dv/tb_borrow_subtract_nibble_swap_unit.sv
`timescale 1ns/1ps
// bench for the subtract-with-borrow and nibble swap unit
module tb_borrow_subtract_nibble_swap_unit;
  logic        sys_clk;      // 10 MHz core clock
  logic        rst_n;        // sync reset, active low
  logic        ce;           // clock enable, high except during the clock enable test
  logic [7:0]  reg_addr;     // register byte address
  logic [31:0] reg_wdata;    // register write data
  logic        reg_wr;       // write strobe
  logic        reg_rd;       // read strobe
  logic [31:0] reg_rdata;    // read data, cycle after strobe
  logic        instr_valid;  // instruction offered
  logic [15:0] instr_word;   // opcode, d, a, f
  logic        instr_ready;  // unit idle
  logic        instr_done;   // finished pulse
  logic [11:0] mem_addr;     // operand address
  logic        mem_rd;       // operand read pulse
  logic        mem_wr;       // operand write pulse
  logic [7:0]  mem_wdata;    // operand write data
  logic [7:0]  mem_rdata;    // operand read data
  int          error_cnt;    // mismatches seen
  int          n_compared;   // comparisons made

  bsnsu_top DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready),
    .instr_done(instr_done), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );

  // free-running clock, 100 ns period
  always #50 sys_clk = ~sys_clk;

  // one comparison; four-state so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // single-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // single-cycle read; data looked at only in the following cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string what);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, what);
    // read data stands one cycle only, then falls back to zero
    @(posedge sys_clk);
    #1 chk(reg_rdata, 32'h0, "read data cleared");
  endtask : rd

  // one instruction: memory answers in the cycle after the read pulse,
  // and shows the inverted byte at other times so stale data is caught
  task automatic exec(input logic [15:0] w, input logic [7:0] fv,
                      input logic [11:0] ea, input logic ed,
                      input logic [7:0] ev);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word  <= w;
    mem_rdata   <= ~fv;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1 chk({mem_rd, instr_ready}, 2'b10, "read pulse");
    chk(mem_addr, ea, "operand address");
    @(posedge sys_clk);
    mem_rdata <= fv;
    #1 chk(mem_rd, 1'b0, "read pulse ends");
    @(posedge sys_clk);
    mem_rdata <= ~fv;
    #1 chk(mem_wr, ed, "write pulse");
    if (ed) chk(mem_wdata, ev, "write data");
    @(posedge sys_clk);
    #1 chk({instr_done, instr_ready}, 2'b11, "completion");
    // done is a single-cycle pulse
    @(posedge sys_clk);
    #1 chk(instr_done, 1'b0, "done pulse ends");
  endtask : exec

  // counts, verdict and end of run
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // main sequence
  initial begin
    sys_clk     = 1'b0;
    rst_n       = 1'b0;
    ce          = 1'b1;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0000_0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    instr_valid = 1'b0;
    instr_word  = 16'h0000;
    mem_rdata   = 8'h00;
    error_cnt   = 0;
    n_compared  = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values; unmapped writes are dropped and read back zero
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0, "unmapped");
    rd(bsnsu_pkg::OFS_CTRL, 32'h0, "ctrl reset");
    rd(bsnsu_pkg::OFS_WREG, 32'h0, "wreg reset");
    rd(bsnsu_pkg::OFS_STAT, 32'h0, "stat reset");
    rd(bsnsu_pkg::OFS_BANK, 32'h0, "bank reset");
    rd(bsnsu_pkg::OFS_INDEX, 32'h0, "index reset");
    $display("test reset done");
    // clear carry borrows one; zero result into accumulator, upper access
    wr(bsnsu_pkg::OFS_WREG, 32'h1A);
    exec({bsnsu_pkg::OPC_SUBB, 2'b00, 8'h70}, 8'h1B, 12'hF70, 1'b0,
         8'h00);
    rd(bsnsu_pkg::OFS_WREG, 32'h00, "zero result");
    rd(bsnsu_pkg::OFS_STAT, 32'h07, "zero flags");
    $display("test borrow zero done");
    // negative result back to the file register through the bank value
    wr(bsnsu_pkg::OFS_WREG, 32'h0E);
    wr(bsnsu_pkg::OFS_STAT, 32'h01);
    wr(bsnsu_pkg::OFS_BANK, 32'h5);
    exec({bsnsu_pkg::OPC_SUBB, 2'b11, 8'h22}, 8'h03, 12'h522, 1'b1,
         8'hF5);
    rd(bsnsu_pkg::OFS_WREG, 32'h0E, "accumulator kept");
    rd(bsnsu_pkg::OFS_STAT, 32'h10, "negative flags");
    $display("test banked negative done");
    // signed overflow at the indexed limit, base wraps past the top
    wr(bsnsu_pkg::OFS_CTRL, 32'h1);
    wr(bsnsu_pkg::OFS_INDEX, 32'hFF0);
    wr(bsnsu_pkg::OFS_WREG, 32'h01);
    wr(bsnsu_pkg::OFS_STAT, 32'h01);
    exec({bsnsu_pkg::OPC_SUBB, 2'b00, 8'h5F}, 8'h80, 12'h04F, 1'b0,
         8'h00);
    rd(bsnsu_pkg::OFS_WREG, 32'h7F, "overflow result");
    rd(bsnsu_pkg::OFS_STAT, 32'h09, "overflow flags");
    $display("test indexed overflow done");
    // swap just above the indexed range, then inside it into W
    exec({bsnsu_pkg::OPC_SWAP, 2'b10, 8'h60}, 8'h53, 12'hF60, 1'b1,
         8'h35);
    exec({bsnsu_pkg::OPC_SWAP, 2'b00, 8'h10}, 8'hA7, 12'h000, 1'b0,
         8'h00);
    rd(bsnsu_pkg::OFS_WREG, 32'h7A, "swapped into W");
    rd(bsnsu_pkg::OFS_STAT, 32'h09, "flags untouched");
    $display("test swap done");
    // a foreign opcode must start no access and change nothing
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word  <= 16'hFC00;
    repeat (3) begin
      @(posedge sys_clk);
      #1 chk(mem_rd, 1'b0, "foreign opcode");
    end
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    rd(bsnsu_pkg::OFS_WREG, 32'h7A, "W after foreign");
    $display("test foreign opcode done");
    // ce low freezes state: strobes and instructions are ignored
    @(posedge sys_clk);
    ce          <= 1'b0;
    instr_valid <= 1'b1;
    instr_word  <= {bsnsu_pkg::OPC_SWAP, 2'b00, 8'h10};
    wr(bsnsu_pkg::OFS_WREG, 32'h55);
    #1 chk({mem_rd, instr_ready}, 2'b01, "frozen handshake");
    @(posedge sys_clk);
    ce          <= 1'b1;
    instr_valid <= 1'b0;
    rd(bsnsu_pkg::OFS_WREG, 32'h7A, "frozen accumulator");
    $display("test clock enable done");
    // mid-run reset returns registers to their reset values
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(bsnsu_pkg::OFS_WREG, {24'h000000, bsnsu_pkg::RST_WREG},
       "wreg after reset");
    rd(bsnsu_pkg::OFS_STAT, {27'h0000000, bsnsu_pkg::RST_STAT},
       "stat after reset");
    $display("test mid-run reset done");
    results();
  end

  // hang guard, well beyond the 120 or so cycles the tests need
  initial begin
    #(3000 * 100);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
endmodule : tb_borrow_subtract_nibble_swap_unit
